// ===== core/rlbp_pkg.sv
// package of constants for the rgb level/brightness pwm block
package rlbp_pkg;
   // step tick
   localparam int STEP_PERIOD_NS  = 25000;
   localparam int CLK_PERIOD_NS   = 100;
   localparam int STEP_CYCLES     = STEP_PERIOD_NS / CLK_PERIOD_NS;
   localparam int STEP_CNT_W      = 8;
   // sequence resolution
   localparam int LEVEL_COUNT     = 8;
   localparam int BRIGHT_COUNT    = 50;
   localparam int LEVEL_W         = 3;
   localparam int BRIGHT_W        = 6;
   // effect timing
   localparam int DELAY_W         = 16;
   localparam logic [DELAY_W-1:0] FADE_STEP_TICKS  = 16'h0FA0;
   localparam logic [DELAY_W-1:0] PULSE_STEP_TICKS = 16'h07D0;
   localparam logic [DELAY_W-1:0] DEMO_HOLD_TICKS  = 16'hFFFF;
   // wishbone register map (byte addresses)
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_COLOUR  = 8'h04;
   localparam logic [7:0] REG_BRIGHT  = 8'h08;
   localparam logic [7:0] REG_CMD     = 8'h0C;
   localparam logic [7:0] REG_STATUS  = 8'h10;
   // ctrl fields
   localparam int CTRL_INVERT_BIT = 0;
   localparam int CTRL_DEMO_BIT   = 1;
   // reset values
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [8:0]  COLOUR_RESET = 9'h1FF;
   localparam logic [5:0]  BRIGHT_RESET = 6'h31;
   // command codes
   localparam logic [7:0] CMD_STOP    = 8'h00;
   localparam logic [7:0] CMD_STATIC  = 8'h01;
   localparam logic [7:0] CMD_FADE    = 8'h02;
   localparam logic [7:0] CMD_PULSE   = 8'h03;
   localparam int CMD_INDEX = 1;
   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_ENABLED  = 2'b01,
      ST_DISABLED = 2'b10
   } rlbp_state_t;
endpackage : rlbp_pkg

// ===== core/rlbp_step_tick.sv
// step tick divider: one-cycle enable every STEP_CYCLES clocks
`timescale 1ns/1ns
module rlbp_step_tick
   import rlbp_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   // control
   input  wire logic run,
   output logic      tick_q
);
   logic [STEP_CNT_W-1:0] cnt_q, cnt_d;
   logic                  tick_d;

   always_comb begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (!run) begin
         cnt_d = '0;
      end else if (cnt_q == STEP_CNT_W'(STEP_CYCLES - 1)) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end
endmodule : rlbp_step_tick

// ===== core/rlbp_top.sv
// rgb led level/brightness pwm with effects, command byte and wishbone regs
`timescale 1ns/1ns
module rlbp_top
   import rlbp_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // received serial bytes
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_valid,
   // led drive
   output logic             led_red_q,
   output logic             led_green_q,
   output logic             led_blue_q
);
   // control/config registers
   logic                 invert_q, invert_d;
   logic                 demo_q, demo_d;
   logic [LEVEL_W-1:0]   colour_q [3];
   logic [LEVEL_W-1:0]   colour_d [3];
   logic [BRIGHT_W-1:0]  bright_q, bright_d;
   logic [31:0]          dat_d;
   logic                 ack_d;
   // command path
   logic [7:0]           serial_receive_buffer_q [2];
   logic [7:0]           serial_receive_buffer_d [2];
   logic                 rx_idx_q, rx_idx_d;
   logic                 cmd_new_q, cmd_new_d;
   logic [7:0]           cmd_q, cmd_d;
   logic                 effect_exit_flag_q, effect_exit_flag_d;
   // effect engine
   rlbp_state_t          state_q, state_d;
   logic [7:0]           effect_q, effect_d;
   logic [DELAY_W-1:0]   delay_q, delay_d;
   logic                 fade_up_q, fade_up_d;
   // pwm counters
   logic [LEVEL_W-1:0]   lvl_q, lvl_d;
   logic [BRIGHT_W-1:0]  bcnt_q, bcnt_d;
   logic [2:0]           pwm_d;
   logic [2:0]           led_d;
   logic                 step_tick;
   logic                 wb_hit;
   logic                 wb_wr;
   logic                 sw_cmd;
   logic [LEVEL_W-1:0]   col_next [3];
   logic [2:0]           col_on;

   rlbp_step_tick u_tick (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .run     (state_q != ST_IDLE),
      .tick_q  (step_tick)
   );

   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes land on the edge where the master samples ack, not one earlier
   assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign sw_cmd = wb_wr && wb_adr_i == REG_CMD && wb_sel_i[0];

   // register bus; ack one cycle after the request is taken
   always_comb begin
      invert_d = invert_q;
      demo_d   = demo_q;
      colour_d = colour_q;
      bright_d = bright_q;
      dat_d    = 32'h0000_0000;
      ack_d    = wb_hit;
      if (wb_wr) begin
         unique case (wb_adr_i)
            REG_CTRL: begin
               if (wb_sel_i[0]) begin
                  invert_d = wb_dat_i[CTRL_INVERT_BIT];
                  demo_d   = wb_dat_i[CTRL_DEMO_BIT];
               end
            end
            REG_COLOUR: begin
               if (wb_sel_i[0]) begin
                  colour_d[0] = wb_dat_i[2:0];
                  colour_d[1] = wb_dat_i[5:3];
               end
               if (wb_sel_i[1]) begin
                  colour_d[2] = wb_dat_i[8:6];
               end
            end
            REG_BRIGHT: begin
               if (wb_sel_i[0]) begin
                  bright_d = wb_dat_i[BRIGHT_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end else if (wb_hit && !wb_we_i) begin
         unique case (wb_adr_i)
            REG_CTRL:   dat_d = {30'h0000_0000, demo_q, invert_q};
            REG_COLOUR: dat_d = {23'h00_0000, colour_q[2], colour_q[1], colour_q[0]};
            REG_BRIGHT: dat_d = {26'h000_0000, bright_q};
            REG_CMD:    dat_d = {24'h00_0000, cmd_q};
            REG_STATUS: dat_d = {12'h000, bcnt_q, lvl_q, effect_exit_flag_q, state_q, effect_q};
            default:    dat_d = 32'h0000_0000;
         endcase
      end
      // effects steer the colour/brightness settings while running
      if (state_q != ST_IDLE && step_tick && delay_q == '0) begin
         if (effect_q == CMD_FADE && demo_q) begin
            colour_d = col_next;   // only the demo walk, so bus writes on a tick survive
         end
         if (effect_q == CMD_FADE || effect_q == CMD_PULSE) begin
            bright_d = fade_up_q ? bright_q + 1'b1 : bright_q - 1'b1;
         end
      end
   end

   // demo colour walk
   always_comb begin
      col_next[0] = colour_q[0] + 1'b1;
      col_next[1] = (colour_q[0] == '1) ? colour_q[1] + 1'b1 : colour_q[1];
      col_next[2] = (colour_q[0] == '1 && colour_q[1] == '1) ? colour_q[2] + 1'b1 : colour_q[2];
      if (effect_q != CMD_FADE || !demo_q) begin
         col_next = colour_q;
      end
   end

   // command byte capture: byte 0 header, byte 1 command code
   always_comb begin
      serial_receive_buffer_d = serial_receive_buffer_q;
      rx_idx_d  = rx_idx_q;
      cmd_new_d = 1'b0;
      cmd_d     = cmd_q;
      if (rx_valid) begin
         serial_receive_buffer_d[rx_idx_q] = rx_byte;
         rx_idx_d = ~rx_idx_q;
         if (rx_idx_q) begin
            cmd_d     = serial_receive_buffer_d[CMD_INDEX];
            cmd_new_d = 1'b1;
         end
      end else if (sw_cmd) begin
         cmd_d     = wb_dat_i[7:0];
         cmd_new_d = 1'b1;
      end
   end

   // effect state machine
   always_comb begin
      state_d            = state_q;
      effect_d           = effect_q;
      delay_d            = delay_q;
      fade_up_d          = fade_up_q;
      effect_exit_flag_d = effect_exit_flag_q;
      if (cmd_new_q && cmd_q == CMD_STOP) begin
         effect_exit_flag_d = 1'b1;
      end
      unique case (state_q)
         ST_IDLE: begin
            effect_exit_flag_d = 1'b0;
            if (cmd_new_q && (cmd_q == CMD_STATIC || cmd_q == CMD_FADE || cmd_q == CMD_PULSE)) begin
               state_d  = ST_ENABLED;
               effect_d = cmd_q;
               delay_d  = '0;
            end else if (demo_q) begin
               state_d  = ST_ENABLED;
               effect_d = CMD_FADE;
               delay_d  = '0;
            end
         end
         ST_ENABLED, ST_DISABLED: begin
            if (effect_exit_flag_q) begin
               state_d            = ST_IDLE;
               effect_d           = CMD_STOP;
               effect_exit_flag_d = 1'b0;
            end else if (step_tick) begin
               if (delay_q != '0) begin
                  delay_d = delay_q - 1'b1;
               end else begin
                  unique case (effect_q)
                     CMD_FADE: begin
                        delay_d = demo_q ? DEMO_HOLD_TICKS : FADE_STEP_TICKS;
                        if (bright_q == BRIGHT_W'(BRIGHT_COUNT - 2)) fade_up_d = 1'b0;
                        if (bright_q == BRIGHT_W'(1)) fade_up_d = 1'b1;
                     end
                     CMD_PULSE: begin
                        delay_d = PULSE_STEP_TICKS;
                        if (bright_q == BRIGHT_W'(BRIGHT_COUNT - 2)) fade_up_d = 1'b0;
                        if (bright_q == BRIGHT_W'(1)) fade_up_d = 1'b1;
                        state_d = (bright_q == '0) ? ST_DISABLED : ST_ENABLED;
                     end
                     default: delay_d = '0;
                  endcase
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // level and brightness counters, colour compare
   always_comb begin
      lvl_d  = lvl_q;
      bcnt_d = bcnt_q;
      if (state_q == ST_IDLE) begin
         lvl_d  = '0;
         bcnt_d = '0;
      end else if (step_tick) begin
         if (lvl_q == LEVEL_W'(LEVEL_COUNT - 1)) begin
            lvl_d = '0;
            if (bcnt_q == BRIGHT_W'(BRIGHT_COUNT - 1)) begin
               bcnt_d = '0;
            end else begin
               bcnt_d = bcnt_q + 1'b1;
            end
         end else begin
            lvl_d = lvl_q + 1'b1;
         end
      end
      for (int c = 0; c < 3; c++) begin
         col_on[c] = lvl_q < colour_q[c];
      end
      pwm_d = col_on;
      if (bcnt_q > bright_q || state_q != ST_ENABLED) begin
         pwm_d = 3'b000;
      end
      led_d = invert_q ? ~pwm_d : pwm_d;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         invert_q           <= CTRL_RESET[CTRL_INVERT_BIT];
         demo_q             <= CTRL_RESET[CTRL_DEMO_BIT];
         colour_q[0]        <= COLOUR_RESET[2:0];
         colour_q[1]        <= COLOUR_RESET[5:3];
         colour_q[2]        <= COLOUR_RESET[8:6];
         bright_q           <= BRIGHT_RESET;
         wb_dat_o           <= 32'h0000_0000;
         wb_ack_o           <= 1'b0;
         serial_receive_buffer_q[0] <= 8'h00;
         serial_receive_buffer_q[1] <= 8'h00;
         rx_idx_q           <= 1'b0;
         cmd_new_q          <= 1'b0;
         cmd_q              <= CMD_STOP;
         effect_exit_flag_q <= 1'b0;
         state_q            <= ST_IDLE;
         effect_q           <= CMD_STOP;
         delay_q            <= '0;
         fade_up_q          <= 1'b0;
         lvl_q              <= '0;
         bcnt_q             <= '0;
         led_red_q          <= 1'b0;
         led_green_q        <= 1'b0;
         led_blue_q         <= 1'b0;
      end else begin
         invert_q           <= invert_d;
         demo_q             <= demo_d;
         colour_q           <= colour_d;
         bright_q           <= bright_d;
         wb_dat_o           <= dat_d;
         wb_ack_o           <= ack_d;
         serial_receive_buffer_q <= serial_receive_buffer_d;
         rx_idx_q           <= rx_idx_d;
         cmd_new_q          <= cmd_new_d;
         cmd_q              <= cmd_d;
         effect_exit_flag_q <= effect_exit_flag_d;
         state_q            <= state_d;
         effect_q           <= effect_d;
         delay_q            <= delay_d;
         fade_up_q          <= fade_up_d;
         lvl_q              <= lvl_d;
         bcnt_q             <= bcnt_d;
         led_red_q          <= led_d[0];
         led_green_q        <= led_d[1];
         led_blue_q         <= led_d[2];
      end
   end
endmodule : rlbp_top

// ===== tb/rgb_led_level_brightness_pwm_tb.sv
// self-checking bench for the rgb level/brightness pwm block
`timescale 1ns/1ns
module rgb_led_level_brightness_pwm_tb;
   import rlbp_pkg::*;
   logic        ref_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_valid;
   logic        led_red_q, led_green_q, led_blue_q;
   logic [7:0]  wb_adr_i, rx_byte;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [8:0]  col;
   int          n_errors = 0;
   int          n_compared = 0;
   int          exp_st, exp_eff, p1, t;
   rlbp_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rx_byte(rx_byte), .rx_valid(rx_valid), .led_red_q(led_red_q),
      .led_green_q(led_green_q), .led_blue_q(led_blue_q));
   rlbp_host_model host_u (.ref_clk(ref_clk), .rx_byte(rx_byte), .rx_valid(rx_valid));
   always #50 ref_clk = ~ref_clk;
   task automatic end_sim;
      if (n_errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n = 0;
      @(posedge ref_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) n_errors++;
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : wb
   task automatic st(input int s, input int e);
      wb(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk("state", s, {30'h0, rd[9:8]});
      if (s != 0) chk("effect", e, {24'h0, rd[7:0]});
   endtask : st
   // model: start codes act only from idle, stop always returns to idle
   task automatic cmd(input bit ser, input logic [7:0] c);
      if (ser) host_u.send_cmd(8'($urandom), c);
      else wb(1'b1, REG_CMD, {24'h0, c}, 4'h1);
      if (c == CMD_STOP) exp_st = 0;
      else if (c <= CMD_PULSE && exp_st == 0) {exp_st, exp_eff} = {32'd1, 32'(c)};
      repeat (4) @(posedge ref_clk);
      st(exp_st, exp_eff);
      wb(1'b0, REG_CMD, 32'h0, 4'hF);
      chk("cmd", {24'h0, c}, rd);
   endtask : cmd
   task automatic wait_red(input logic v);
      t = 0;
      do begin
         @(posedge ref_clk);
         t++;
      end while (led_red_q !== v && t < 3000);
   endtask : wait_red
   initial begin
      repeat (40000) @(posedge ref_clk);
      n_errors++;
      end_sim();
   end
   initial begin
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
      {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'h0, 32'h0000_0000};
      {exp_st, exp_eff} = 64'h0;
      void'($urandom(32'h2aa7));
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      wb(1'b0, REG_CTRL, 32'h0, 4'hF);
      chk("ctrl", CTRL_RESET, rd);
      wb(1'b0, REG_BRIGHT, 32'h0, 4'hF);
      chk("bright", {26'h0, BRIGHT_RESET}, rd);
      wb(1'b1, REG_COLOUR, 32'h0, 4'h0);
      wb(1'b0, REG_COLOUR, 32'h0, 4'hF);
      chk("colour", {23'h0, COLOUR_RESET}, rd);
      wb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
      wb(1'b0, 8'h20, 32'h0, 4'hF);
      chk("unmapped", 32'h0, rd);
      st(0, 0);
      chk("leds idle", 32'h0, {29'h0, led_red_q, led_green_q, led_blue_q});
      col = {3'($urandom), 3'($urandom), 3'h4};
      wb(1'b1, REG_COLOUR, {23'h0, col}, 4'hF);
      wb(1'b1, REG_BRIGHT, 32'h31, 4'hF);
      cmd(1'b1, CMD_STATIC);
      wb(1'b0, REG_COLOUR, 32'h0, 4'hF);
      chk("colour set", {23'h0, col}, rd);
      wait_red(1'b0);
      wait_red(1'b1);
      wait_red(1'b0);
      chk("red on", 4 * STEP_CYCLES, t);
      wait_red(1'b1);
      chk("red off", 4 * STEP_CYCLES, t);
      // equal bus latency, so nine ticks apart means nine counter steps
      wb(1'b0, REG_STATUS, 32'h0, 4'hF);
      p1 = rd[19:14] * LEVEL_COUNT + rd[13:11];
      repeat (9 * STEP_CYCLES - 3) @(posedge ref_clk);
      wb(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk("position", (p1 + 9) % (LEVEL_COUNT * BRIGHT_COUNT), rd[19:14] * LEVEL_COUNT + rd[13:11]);
      wb(1'b1, REG_BRIGHT, 32'h0, 4'hF);
      repeat (4) begin
         repeat (300) @(posedge ref_clk);
         wb(1'b0, REG_STATUS, 32'h0, 4'hF);
         if (rd[19:14] != 6'h00) chk("masked", 32'h0, {29'h0, led_red_q, led_green_q, led_blue_q});
      end
      cmd(1'b1, CMD_STOP);
      chk("leds stop", 32'h0, {29'h0, led_red_q, led_green_q, led_blue_q});
      cmd(1'b1, CMD_FADE);
      cmd(1'b0, CMD_STATIC);
      cmd(1'b0, CMD_STOP);
      cmd(1'b0, CMD_PULSE);
      cmd(1'b1, CMD_STOP);
      cmd(1'b1, 8'hA5);
      cmd(1'b1, 8'($urandom_range(255, 4)));
      wb(1'b1, REG_CTRL, 32'h1, 4'hF);
      repeat (3) @(posedge ref_clk);
      chk("leds inverted", 32'h7, {29'h0, led_red_q, led_green_q, led_blue_q});
      wb(1'b1, REG_CTRL, 32'h2, 4'hF);
      repeat (4) @(posedge ref_clk);
      st(1, CMD_FADE);
      wb(1'b1, REG_CTRL, 32'h0, 4'hF);
      {exp_st, exp_eff} = {32'd1, 32'(CMD_FADE)};
      cmd(1'b0, CMD_STOP);
      end_sim();
   end
endmodule : rgb_led_level_brightness_pwm_tb

// ===== tb/rlbp_host_model.sv
// host terminal model: sends raw command byte pairs
`timescale 1ns/1ns
module rlbp_host_model (
   // clock
   input wire logic  ref_clk,
   // serial bytes out
   output logic [7:0] rx_byte,
   output logic       rx_valid
);
   initial begin
      rx_byte  = 8'h00;
      rx_valid = 1'b0;
   end
   // header then one raw binary code byte, never ascii text
   task automatic send_cmd(input logic [7:0] hdr, input logic [7:0] code);
      @(posedge ref_clk);
      rx_byte  <= hdr;
      rx_valid <= 1'b1;
      @(posedge ref_clk);
      rx_byte  <= code;
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      rx_byte  <= ~code; // released line keeps no stale value
   endtask : send_cmd
endmodule : rlbp_host_model

// ===== tb/rlbp_top_asserts.sv
// port checker for the rgb level/brightness pwm block
`timescale 1ns/1ns
module rlbp_top_asserts
   import rlbp_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // serial bytes
   input wire logic [7:0]  rx_byte,
   input wire logic        rx_valid,
   // led drive
   input wire logic        led_red_q,
   input wire logic        led_green_q,
   input wire logic        led_blue_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic       rd_st;
   logic       hit;
   logic       upd;
   logic [2:0] leds;
   logic [2:0] lvl;
   logic [8:0] col_q, col_d;
   logic [5:0] bri_q, bri_d;
   logic       inv_q, inv_d;
   assign leds  = {led_red_q, led_green_q, led_blue_q};
   assign lvl   = wb_dat_o[13:11];
   assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i == REG_STATUS;
   assign hit   = wb_adr_i inside {REG_CTRL, REG_COLOUR, REG_BRIGHT, REG_CMD, REG_STATUS};
   assign upd   = wb_ack_o && (!wb_we_i || wb_sel_i == 4'hF);
   // mirrors follow reads too, since effects rewrite the colour and brightness registers
   always_comb begin
      col_d = col_q;
      bri_d = bri_q;
      inv_d = inv_q;
      if (upd && wb_adr_i == REG_COLOUR) col_d = wb_we_i ? wb_dat_i[8:0] : wb_dat_o[8:0];
      if (upd && wb_adr_i == REG_BRIGHT) bri_d = wb_we_i ? wb_dat_i[5:0] : wb_dat_o[5:0];
      if (upd && wb_adr_i == REG_CTRL) inv_d = wb_we_i ? wb_dat_i[0] : wb_dat_o[0];
   end
   always_ff @(posedge ref_clk) begin
      col_q <= sys_rst ? COLOUR_RESET : col_d;
      bri_q <= sys_rst ? BRIGHT_RESET : bri_d;
      inv_q <= sys_rst ? 1'b0 : inv_d;
   end
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");
   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked after one cycle");
   a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && !hit |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_state_legal: assert property (rd_st |-> wb_dat_o[9:8] != 2'b11) else $error("illegal state");
   a_bright_range: assert property (rd_st |-> wb_dat_o[19:14] < BRIGHT_COUNT)
      else $error("brightness count out of range");
   a_idle_dark: assert property (rd_st && wb_dat_o[9:8] != ST_ENABLED |-> leds == {3{inv_q}})
      else $error("leds lit outside enabled state");
   a_led_pattern: assert property (rd_st && wb_dat_o[9:8] == ST_ENABLED && wb_dat_o[7:0] == CMD_STATIC
      |-> leds == ({lvl < col_q[2:0], lvl < col_q[5:3], lvl < col_q[8:6]} & {3{wb_dat_o[19:14] <= bri_q}} ^ {3{inv_q}}))
      else $error("led pattern wrong for counters");
endmodule : rlbp_top_asserts
bind rlbp_top rlbp_top_asserts chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_byte(rx_byte), .rx_valid(rx_valid),
   .led_red_q(led_red_q), .led_green_q(led_green_q), .led_blue_q(led_blue_q));
